/* pkcc_top.sv */
`default_nettype none
module pkcc_top
    import pkcc_pkg::*;
#(
    parameter logic [3:0] GOOD_PERIODS = LOCK_PERIODS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Crystal and power state
    input wire logic xtal_in,
    input wire logic full_power_state,
    input wire logic battery_saving_state,
    // Special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Clocks and core control
    output logic pll_tick,
    output logic core_clk_en,
    output logic meter_clk_en,
    output logic pll_locked,
    output logic core_reset,
    output logic lock_fault_flag,
    output logic metering_shutdown,
    output logic core_shutdown,
    // Unlocked timekeeping write
    output logic tk_wr,
    output logic [7:0] tk_addr,
    output logic [7:0] tk_data
);

    typedef struct packed {
        logic [7:0] key;
        pkcc_key_e arm;
        logic [7:0] pwr;
        logic fault;
        logic core_rst;
        logic meter_shut;
        logic core_off;
        logic [7:0] rdata;
        logic tk_wr;
        logic [7:0] tk_addr;
        logic [7:0] tk_data;
    } pkcc_top_s;

    pkcc_top_s st_q;
    pkcc_top_s st_d;

    pkcc_clk_if clk ();

    pkcc_clk_gen #(
        .GOOD_PERIODS(GOOD_PERIODS)
    ) u_gen (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .xtal_in(xtal_in),
        .clk(clk.gen)
    );

    function automatic logic is_timekeep(input logic [7:0] a);
        is_timekeep = (a == ADDR_IRQ_PIN_CFG) || (a == ADDR_CENTISEC) ||
            (a == ADDR_SECONDS) || (a == ADDR_MINUTES) || (a == ADDR_HOURS);
    endfunction

    assign clk.core_div = st_q.pwr[2:0];

    // ------------------------------------------------------------
    // Register writes and key sequencing
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.tk_wr = 1'b0;
        if (sfr_wr) begin
            if (sfr_addr == ADDR_UNLOCK_KEY) begin
                st_d.key = sfr_wdata;
                if (sfr_wdata == KEY_POWER) begin
                    st_d.arm = KS_POWER;
                end else if (sfr_wdata == KEY_TIMEKEEP) begin
                    st_d.arm = KS_TIMEKEEP;
                end else begin
                    st_d.arm = KS_NONE;
                end
            end else if (sfr_addr == ADDR_POWER_CTRL) begin
                if (st_q.arm == KS_POWER) begin
                    st_d.pwr = (sfr_wdata & POWER_CTRL_WMASK) | POWER_CTRL_FIXED;
                end
                st_d.arm = KS_NONE;
            end else if (is_timekeep(sfr_addr)) begin
                if (st_q.arm == KS_TIMEKEEP) begin
                    st_d.tk_wr = 1'b1;
                    st_d.tk_addr = sfr_addr;
                    st_d.tk_data = sfr_wdata;
                end
                st_d.arm = KS_NONE;
            end else begin
                st_d.arm = KS_NONE;
            end
        end
        // Acknowledge clears the fault, but a new loss of lock wins.
        if (sfr_wr && sfr_addr == ADDR_MEAS_START && sfr_wdata[POS_FAULT_ACK]) begin
            st_d.fault = 1'b0;
        end
        if (clk.lock_lost) begin
            st_d.fault = 1'b1;
        end
        st_d.core_rst = !clk.locked;
        st_d.meter_shut = st_q.pwr[POS_METER_SHUT] && full_power_state;
        st_d.core_off = st_q.pwr[POS_CORE_OFF] && battery_saving_state;
        // Reads answer one cycle later; unmapped addresses read zero.
        st_d.rdata = 8'h00;
        if (sfr_rd) begin
            if (sfr_addr == ADDR_UNLOCK_KEY) begin
                st_d.rdata = st_q.key;
            end else if (sfr_addr == ADDR_POWER_CTRL) begin
                st_d.rdata = st_q.pwr;
            end else if (sfr_addr == ADDR_PERIPHERAL_CFG) begin
                st_d.rdata[POS_LOCK_FAULT] = st_q.fault;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '{key: UNLOCK_KEY_RST, arm: KS_NONE, pwr: POWER_CTRL_RST, fault: 1'b0,
                core_rst: 1'b1, meter_shut: 1'b0, core_off: 1'b0, rdata: 8'h00,
                tk_wr: 1'b0, tk_addr: 8'h00, tk_data: 8'h00};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sfr_rdata = st_q.rdata;
    assign pll_tick = clk.pll_tick;
    assign core_clk_en = clk.core_tick;
    assign meter_clk_en = clk.meter_tick;
    assign pll_locked = clk.locked;
    assign core_reset = st_q.core_rst;
    assign lock_fault_flag = st_q.fault;
    assign metering_shutdown = st_q.meter_shut;
    assign core_shutdown = st_q.core_off;
    assign tk_wr = st_q.tk_wr;
    assign tk_addr = st_q.tk_addr;
    assign tk_data = st_q.tk_data;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_power_key_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sfr_wr && sfr_addr == ADDR_POWER_CTRL && st_q.arm != KS_POWER) |=> $stable(st_q.pwr))
        else $error("power control changed without key");
    a_power_key_take: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sfr_wr && sfr_addr == ADDR_POWER_CTRL && st_q.arm == KS_POWER)
        |=> st_q.pwr[6:0] == ($past(sfr_wdata[6:0]) & POWER_CTRL_WMASK[6:0]))
        else $error("keyed power control write lost");
    a_timekeep_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_q.tk_wr |-> ($past(st_q.arm) == KS_TIMEKEEP && $past(is_timekeep(sfr_addr))))
        else $error("timekeeping write without key");
    a_key_single_use: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sfr_wr && sfr_addr != ADDR_UNLOCK_KEY) |=> st_q.arm == KS_NONE)
        else $error("unlock survived a write");
    a_fault_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk.lock_lost |=> (st_q.fault && st_q.core_rst))
        else $error("lock loss not reported");
    a_fault_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sfr_wr && sfr_addr == ADDR_MEAS_START && sfr_wdata[POS_FAULT_ACK] && !clk.lock_lost)
        |=> !st_q.fault)
        else $error("fault acknowledge ignored");
    a_meter_shut: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (st_q.pwr[POS_METER_SHUT] && full_power_state) |=> st_q.meter_shut)
        else $error("metering not shut down");
    a_core_shut: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (st_q.core_off) |-> $past(st_q.pwr[POS_CORE_OFF] && battery_saving_state))
        else $error("core shut down without cause");
    a_bit7_fixed: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_q.pwr[7] && !st_q.pwr[3])
        else $error("fixed power control bits changed");

    // ------------------------------------------------------------
    // Key, fault, reset, shutdown and core tick checks
    // ------------------------------------------------------------
    a_timekeep_take: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sfr_wr && is_timekeep(sfr_addr) && st_q.arm == KS_TIMEKEEP)
        |=> (st_q.tk_wr && st_q.tk_addr == $past(sfr_addr)
        && st_q.tk_data == $past(sfr_wdata)))
        else $error("keyed timekeeping write lost");
    a_key_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sfr_wr && sfr_addr == ADDR_UNLOCK_KEY) |=> st_q.key == $past(sfr_wdata))
        else $error("key register not updated");
    a_fault_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (st_q.fault && !(sfr_wr && sfr_addr == ADDR_MEAS_START && sfr_wdata[POS_FAULT_ACK]))
        |=> st_q.fault)
        else $error("fault cleared without acknowledge");
    a_core_rst_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_q.core_rst == !$past(clk.locked))
        else $error("core reset does not follow lock");
    a_meter_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(st_q.pwr[POS_METER_SHUT] && full_power_state) |=> !st_q.meter_shut)
        else $error("metering shut down without cause");
    a_core_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(st_q.pwr[POS_CORE_OFF] && battery_saving_state) |=> !st_q.core_off)
        else $error("core shutdown held without cause");
    a_core_tick_pll: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk.core_tick |-> clk.pll_tick)
        else $error("core tick off the PLL tick");

endmodule
`default_nettype wire

/* pkcc_pkg.sv */
`default_nettype none
package pkcc_pkg;

    // ------------------------------------------------------------
    // Special function register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_UNLOCK_KEY = 8'hc1;
    localparam logic [7:0] ADDR_POWER_CTRL = 8'hc5;
    localparam logic [7:0] ADDR_PERIPHERAL_CFG = 8'hf4;
    localparam logic [7:0] ADDR_MEAS_START = 8'hd8;
    localparam logic [7:0] ADDR_IRQ_PIN_CFG = 8'hff;
    localparam logic [7:0] ADDR_CENTISEC = 8'ha2;
    localparam logic [7:0] ADDR_SECONDS = 8'ha3;
    localparam logic [7:0] ADDR_MINUTES = 8'ha4;
    localparam logic [7:0] ADDR_HOURS = 8'ha5;

    // ------------------------------------------------------------
    // Keys, field positions and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_POWER = 8'ha7;
    localparam logic [7:0] KEY_TIMEKEEP = 8'hea;
    localparam logic [7:0] UNLOCK_KEY_RST = 8'h00;
    localparam logic [7:0] POWER_CTRL_RST = 8'h82;
    localparam logic [7:0] POWER_CTRL_WMASK = 8'h77;
    localparam logic [7:0] POWER_CTRL_FIXED = 8'h80;
    localparam int POS_METER_SHUT = 6;
    localparam int POS_CORE_OFF = 4;
    localparam int POS_LOCK_FAULT = 4;
    localparam int POS_FAULT_ACK = 6;
    localparam logic [2:0] CORE_DIV_RST = 3'h2;

    // ------------------------------------------------------------
    // Clock figures and derived counts
    // ------------------------------------------------------------
    localparam longint SYS_CLK_HZ = 125000000;
    localparam longint XTAL_HZ = 32768;
    localparam longint PLL_HZ = 4096000;
    localparam int NCO_BITS = 20;
    localparam logic [7:0] PLL_MULT = 8'(PLL_HZ / XTAL_HZ);
    localparam logic [NCO_BITS-1:0] NCO_INC_NOM =
        NCO_BITS'((PLL_HZ << NCO_BITS) / SYS_CLK_HZ);
    localparam logic [2:0] METER_DIV = 3'h5;
    localparam logic [3:0] LOCK_PERIODS = 4'h4;

    // ------------------------------------------------------------
    // Key sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KS_NONE = 2'b00,
        KS_POWER = 2'b01,
        KS_TIMEKEEP = 2'b10
    } pkcc_key_e;

endpackage
`default_nettype wire

/* pkcc_clk_if.sv */
`default_nettype none
interface pkcc_clk_if;
    logic [2:0] core_div;
    logic pll_tick;
    logic core_tick;
    logic meter_tick;
    logic locked;
    logic lock_lost;

    modport gen (
        input core_div,
        output pll_tick,
        output core_tick,
        output meter_tick,
        output locked,
        output lock_lost
    );

    modport ctl (
        output core_div,
        input pll_tick,
        input core_tick,
        input meter_tick,
        input locked,
        input lock_lost
    );
endinterface
`default_nettype wire

/* pkcc_clk_gen.sv */
`default_nettype none
module pkcc_clk_gen
    import pkcc_pkg::*;
#(
    parameter logic [3:0] GOOD_PERIODS = LOCK_PERIODS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Crystal reference level
    input wire logic xtal_in,
    // Clock tick carrier
    pkcc_clk_if.gen clk
);

    generate
        if (GOOD_PERIODS == 4'h0) begin : g_bad
            $error("GOOD_PERIODS must be at least one");
        end
    endgenerate

    typedef struct packed {
        logic [NCO_BITS-1:0] acc;
        logic [NCO_BITS-1:0] inc;
        logic [7:0] pll_cnt;
        logic xtal_prev;
        logic [3:0] good_cnt;
        logic locked;
        logic lock_lost;
        logic [6:0] div_cnt;
        logic [2:0] met_cnt;
        logic pll_tick;
        logic core_tick;
        logic meter_tick;
    } pkcc_gen_s;

    pkcc_gen_s st_q;
    pkcc_gen_s st_d;

    function automatic logic [6:0] div_mask(input logic [2:0] code);
        div_mask = 7'((8'h01 << code) - 8'h01);
    endfunction

    logic [NCO_BITS:0] sum;
    logic carry;
    logic xtal_edge;
    logic in_band;

    always_comb begin
        st_d = st_q;
        sum = {1'b0, st_q.acc} + {1'b0, st_q.inc};
        carry = sum[NCO_BITS];
        xtal_edge = xtal_in && !st_q.xtal_prev;
        in_band = (st_q.pll_cnt >= PLL_MULT - 8'h01) && (st_q.pll_cnt <= PLL_MULT + 8'h01);
        st_d.acc = sum[NCO_BITS-1:0];
        st_d.xtal_prev = xtal_in;
        st_d.lock_lost = 1'b0;
        st_d.pll_tick = carry;
        // Core tick once per 2^code PLL ticks; metering tick once per five.
        st_d.core_tick = carry && ((st_q.div_cnt & div_mask(clk.core_div)) ==
            div_mask(clk.core_div));
        st_d.meter_tick = carry && (st_q.met_cnt == METER_DIV - 3'h1);
        if (carry) begin
            st_d.div_cnt = st_q.div_cnt + 7'h01;
            st_d.met_cnt = (st_q.met_cnt == METER_DIV - 3'h1) ? 3'h0 : st_q.met_cnt + 3'h1;
            st_d.pll_cnt = st_q.pll_cnt + 8'h01;
        end
        // Each crystal period more than one tick off trims the oscillator towards the multiple.
        if (xtal_edge) begin
            st_d.pll_cnt = {7'h00, carry};
            if (st_q.pll_cnt < PLL_MULT - 8'h01) begin
                st_d.inc = st_q.inc + NCO_BITS'(1);
            end else if (st_q.pll_cnt > PLL_MULT + 8'h01) begin
                st_d.inc = st_q.inc - NCO_BITS'(1);
            end
            if (in_band) begin
                if (st_q.good_cnt != GOOD_PERIODS) begin
                    st_d.good_cnt = st_q.good_cnt + 4'h1;
                end else begin
                    st_d.locked = 1'b1;
                end
            end else begin
                st_d.good_cnt = 4'h0;
                st_d.locked = 1'b0;
                st_d.lock_lost = st_q.locked;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '{acc: '0, inc: NCO_INC_NOM, pll_cnt: 8'h00, xtal_prev: 1'b0,
                good_cnt: 4'h0, locked: 1'b0, lock_lost: 1'b0, div_cnt: 7'h00,
                met_cnt: 3'h0, pll_tick: 1'b0, core_tick: 1'b0, meter_tick: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign clk.pll_tick = st_q.pll_tick;
    assign clk.core_tick = st_q.core_tick;
    assign clk.meter_tick = st_q.meter_tick;
    assign clk.locked = st_q.locked;
    assign clk.lock_lost = st_q.lock_lost;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_core_full_rate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (st_q.pll_tick && $past(clk.core_div) == 3'h0) |-> st_q.core_tick)
        else $error("core tick missed at full rate");
    a_meter_spacing: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_q.meter_tick |-> ##1 !st_q.meter_tick [*4])
        else $error("metering ticks too close");
    a_lock_lost_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_q.lock_lost |-> ($past(st_q.locked) && !st_q.locked))
        else $error("lock loss without prior lock");

endmodule
`default_nettype wire

/* pkcc_top_test.sv */
`default_nettype none
module pkcc_top_test
    import pkcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic xtal_in = 1'b0;
    logic full_power_state = 1'b0;
    logic battery_saving_state = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata, tk_addr, tk_data;
    logic pll_tick, core_clk_en, meter_clk_en, pll_locked, core_reset;
    logic lock_fault_flag, metering_shutdown, core_shutdown, tk_wr;
    int n_mismatch = 0;
    int num_checks = 0;
    int xtal_half = 1907;
    int tk_count = 0;
    int cnt;
    logic [7:0] tk_list [5] = '{8'hff, 8'ha2, 8'ha3, 8'ha4, 8'ha5};

    pkcc_top #(.GOOD_PERIODS(4'h1)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .xtal_in(xtal_in),
        .full_power_state(full_power_state), .battery_saving_state(battery_saving_state),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .pll_tick(pll_tick), .core_clk_en(core_clk_en),
        .meter_clk_en(meter_clk_en), .pll_locked(pll_locked), .core_reset(core_reset),
        .lock_fault_flag(lock_fault_flag), .metering_shutdown(metering_shutdown),
        .core_shutdown(core_shutdown), .tk_wr(tk_wr), .tk_addr(tk_addr), .tk_data(tk_data)
    );

    // ------------------------------------------------------------
    // Clock, crystal and watchdog
    // ------------------------------------------------------------
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        forever begin
            repeat (xtal_half) @(posedge sys_clk);
            xtal_in <= ~xtal_in;
            repeat (xtal_half + 1) @(posedge sys_clk);
            xtal_in <= ~xtal_in;
        end
    end

    always @(posedge sys_clk) begin
        if (tk_wr === 1'b1) begin
            tk_count <= tk_count + 1;
        end
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        n_mismatch++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        #1;
        chk(name, {24'h0, sfr_rdata}, {24'h0, exp});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_lock(input logic lvl);
        int g;
        g = 0;
        while (pll_locked !== lvl && g < 40000) begin
            @(posedge sys_clk);
            #1;
            g++;
        end
        chk("pll_locked", {31'h0, pll_locked}, {31'h0, lvl});
    endtask

    task automatic count_core(input int n, output int n_core);
        int k;
        k = 0;
        n_core = 0;
        while (k < n) begin
            @(posedge sys_clk);
            #1;
            if (pll_tick === 1'b1) k++;
            if (core_clk_en === 1'b1) n_core++;
        end
    endtask

    task automatic meter_gap(output int n);
        int g;
        g = 0;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            g++;
        end while (meter_clk_en !== 1'b1 && g < 2000);
        do begin
            @(posedge sys_clk);
            #1;
            if (pll_tick === 1'b1) n++;
        end while (meter_clk_en !== 1'b1 && n < 20);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        settle(1);
        chk("core_reset", {31'h0, core_reset}, 32'h1);
        rd_chk("unlock_key", ADDR_UNLOCK_KEY, 8'h00);
        rd_chk("power_ctrl", ADDR_POWER_CTRL, 8'h82);
        count_core(8, cnt);
        count_core(128, cnt);
        chk("core_ticks", cnt, 128 >> CORE_DIV_RST);
        rd_chk("unmapped", 8'h10, 8'h00);
        wr(ADDR_POWER_CTRL, 8'h40);
        rd_chk("power_ctrl", ADDR_POWER_CTRL, 8'h82);
        wr(ADDR_UNLOCK_KEY, KEY_POWER);
        wr(ADDR_MEAS_START, 8'h00);
        wr(ADDR_POWER_CTRL, 8'h40);
        rd_chk("power_ctrl", ADDR_POWER_CTRL, 8'h82);
        wr(ADDR_UNLOCK_KEY, KEY_TIMEKEEP);
        wr(ADDR_POWER_CTRL, 8'h40);
        rd_chk("power_ctrl", ADDR_POWER_CTRL, 8'h82);
        rd_chk("unlock_key", ADDR_UNLOCK_KEY, 8'hea);
        full_power_state <= 1'b1;
        battery_saving_state <= 1'b1;
        wr(ADDR_UNLOCK_KEY, KEY_POWER);
        rd_chk("unlock_key", ADDR_UNLOCK_KEY, 8'ha7);
        wr(ADDR_POWER_CTRL, 8'h57);
        rd_chk("power_ctrl", ADDR_POWER_CTRL, 8'hd7);
        settle(2);
        chk("metering_shutdown", {31'h0, metering_shutdown}, 32'h1);
        chk("core_shutdown", {31'h0, core_shutdown}, 32'h1);
        full_power_state <= 1'b0;
        battery_saving_state <= 1'b0;
        settle(3);
        chk("metering_shutdown", {31'h0, metering_shutdown}, 32'h0);
        chk("core_shutdown", {31'h0, core_shutdown}, 32'h0);
        wr(ADDR_POWER_CTRL, 8'h02);
        rd_chk("power_ctrl", ADDR_POWER_CTRL, 8'hd7);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_UNLOCK_KEY, KEY_TIMEKEEP);
            wr(tk_list[i], 8'h10 + 8'(i));
            wr(ADDR_UNLOCK_KEY, 8'h00);
            settle(3);
            chk("tk_count", tk_count, i + 1);
            chk("tk_addr", {24'h0, tk_addr}, {24'h0, tk_list[i]});
            chk("tk_data", {24'h0, tk_data}, 32'h10 + i);
        end
        rd_chk("unlock_key", ADDR_UNLOCK_KEY, 8'h00);
        wr(ADDR_SECONDS, 8'h55);
        wr(ADDR_UNLOCK_KEY, KEY_POWER);
        wr(ADDR_SECONDS, 8'h55);
        wr(ADDR_UNLOCK_KEY, KEY_TIMEKEEP);
        wr(ADDR_UNLOCK_KEY, 8'h00);
        wr(ADDR_HOURS, 8'h55);
        settle(3);
        chk("tk_count", tk_count, 5);
        wait_lock(1'b1);
        settle(1);
        chk("core_reset", {31'h0, core_reset}, 32'h0);
        cnt = 0;
        repeat (1000) begin
            @(posedge sys_clk);
            #1;
            if (pll_tick === 1'b1) cnt++;
        end
        chk("pll_rate", {31'h0, cnt >= 32 && cnt <= 33}, 32'h1);
        for (int div = 0; div < 8; div++) begin
            wr(ADDR_UNLOCK_KEY, KEY_POWER);
            wr(ADDR_POWER_CTRL, 8'(div));
            rd_chk("power_ctrl", ADDR_POWER_CTRL, 8'h80 | 8'(div));
            count_core(8, cnt);
            count_core(128, cnt);
            chk("core_ticks", cnt, 128 >> div);
            meter_gap(cnt);
            chk("meter_gap", cnt, 5);
        end
        xtal_half = 400;
        wait_lock(1'b0);
        settle(2);
        chk("core_reset", {31'h0, core_reset}, 32'h1);
        chk("lock_fault_flag", {31'h0, lock_fault_flag}, 32'h1);
        rd_chk("peripheral_cfg", ADDR_PERIPHERAL_CFG, 8'h10);
        xtal_half = 1907;
        wait_lock(1'b1);
        settle(1);
        chk("core_reset", {31'h0, core_reset}, 32'h0);
        chk("lock_fault_flag", {31'h0, lock_fault_flag}, 32'h1);
        wr(ADDR_MEAS_START, 8'h40);
        settle(1);
        chk("lock_fault_flag", {31'h0, lock_fault_flag}, 32'h0);
        rd_chk("peripheral_cfg", ADDR_PERIPHERAL_CFG, 8'h00);
        rd_chk("meas_start", ADDR_MEAS_START, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
